// >>> hdl/dct_pkg.sv
// Package for the DRAM timing and register port block: constants and types.
// Assumes a single processor bus clock and a synchronous active-low reset copy.
// Functional notes
// (R1) EDO moves column address half clock after column strobe; FPM holds it a cycle
// (R2) FPM reads: first access two or three waits, burst beats one wait each
// (R3) EDO reads also allow zero-wait burst beats after two-wait first access
// (R4) Writes: two clocks row-to-column strobe at two waits; three waits selectable
// (R5) Writes also accept one wait on every beat including the first
// (R6) Delayed address strobe adds one clock before the row strobe
// (R7) Config bit 15 set selects FPM sequencing, clear selects EDO
// (R8) Software sets bit 10 according to processor variant at high clock rates
// (R9) Config bit 10 registers the address strobe one extra clock before use
// (R10) Register port is an 8-bit device, one byte per bus beat
// (R11) Burst reads and writes move the 16-bit config word in one instruction
// (R12) Register reads wait 3,2,2,2; register writes wait 2,1,1,1
// (R13) Port leaves idle on strobe and select, branches on direction, loops on last-beat
// (R14) Ready driven in transfer state; internal flag raised one state earlier
// (R15) Write transfer decodes two byte-select lines into one of four load enables
// (R16) Reads mux the addressed byte by byte-select lines onto the data bus
// (R17) Data output enable only during reads, delayed to avoid transceiver contention
// (R18) Outside logic drives transceiver direction and active-low enable
// (R19) After final beat, return idle, drop ready, enables and output enable in one clock
package dct_pkg;

    localparam int DATA_W = 8;
    localparam int NREG   = 4;

    // Configuration word layout
    localparam int CFG_FPM_BIT       = 15;
    localparam int CFG_ADS_DLY_BIT   = 10;
    localparam int CFG_WR_FIRST3_BIT = 4;
    localparam int CFG_WR_FIRST2_BIT = 5;
    localparam int CFG_RD_BURST1_BIT = 2;
    localparam int CFG_RD_FIRST3_BIT = 0;

    // Slowest wait states, address strobe delay off, until software programs the word
    localparam logic [15:0] CFG_RESET = 16'h8037;
    localparam logic [7:0]  REG_RESET = 8'h00;

    // Register indices on the byte-select lines
    localparam logic [1:0] IDX_CFG_LO = 2'h0;
    localparam logic [1:0] IDX_CFG_HI = 2'h1;

    // Register port wait profiles
    localparam logic [1:0] PORT_RD_FIRST = 2'h3;
    localparam logic [1:0] PORT_RD_NEXT  = 2'h2;
    localparam logic [1:0] PORT_WR_FIRST = 2'h2;
    localparam logic [1:0] PORT_WR_NEXT  = 2'h1;

    typedef enum logic [2:0] {
        P_IDLE = 3'b001,
        P_WAIT = 3'b010,
        P_XFER = 3'b100
    } dct_port_st_t;

    typedef enum logic [4:0] {
        D_IDLE  = 5'b00001,
        D_DELAY = 5'b00010,
        D_ROW   = 5'b00100,
        D_COL   = 5'b01000,
        D_PRE   = 5'b10000
    } dct_dram_st_t;

endpackage : dct_pkg

// >>> hdl/dct_regs.sv
// Four byte-wide internal registers with one load enable each.
// Read data come out of a register, selected by the byte-select lines.
`timescale 1ns/1ps
module dct_regs
    import dct_pkg::*;
#(
    parameter int W = DATA_W,
    parameter int N = NREG
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [N-1:0]     wr_en,
    input  wire logic [W-1:0]     wdata,
    input  wire logic [1:0]       rsel,
    output logic      [W-1:0]     rdata,
    output logic      [2*W-1:0]   cfg
);

    logic [W-1:0] mem_reg  [N];
    logic [W-1:0] mem_next [N];
    logic [W-1:0] rdata_reg;
    logic [W-1:0] rdata_next;

    always_comb begin
        for (int i = 0; i < N; i++) begin
            mem_next[i] = wr_en[i] ? wdata : mem_reg[i]; // R15
        end
        rdata_next = mem_reg[rsel]; // R16
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < N; i++) begin
                mem_reg[i] <= REG_RESET;
            end
            mem_reg[IDX_CFG_LO] <= CFG_RESET[7:0];
            mem_reg[IDX_CFG_HI] <= CFG_RESET[15:8];
            rdata_reg <= REG_RESET;
        end else begin
            for (int i = 0; i < N; i++) begin
                mem_reg[i] <= mem_next[i];
            end
            rdata_reg <= rdata_next;
        end
    end

    assign rdata = rdata_reg;
    assign cfg   = {mem_reg[IDX_CFG_HI], mem_reg[IDX_CFG_LO]};

endmodule : dct_regs

// >>> hdl/dct_top.sv
// DRAM access timing sequencer and 8-bit internal register port.
// Assumes all inputs are synchronous to clk and the DRAM address mux is outside.
`timescale 1ns/1ps
module dct_top
    import dct_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              addr_strobe_n,
    input  wire logic              port_sel,
    input  wire logic              dram_sel,
    input  wire logic              wr_rd,
    input  wire logic              last_beat_n,
    input  wire logic              byte_sel1_n,
    input  wire logic              byte_sel0_n,
    input  wire logic [DATA_W-1:0] data_in,
    output logic      [DATA_W-1:0] data_out,
    output logic                   data_oe_n,
    output logic                   ready_n,
    output logic                   dram_ras_n,
    output logic                   dram_cas_n,
    output logic                   dram_col_sel,
    output logic                   dram_col_adv,
    output logic                   dram_edo_mode
);

    // Reset release
    logic       rst_s1_reg;
    logic       rst_s2_reg;
    logic       srst_n;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end

    assign srst_n = rst_s2_reg;

    // Register file
    logic [NREG-1:0]   wr_en;
    logic [DATA_W-1:0] rd_byte;
    logic [15:0]       cfg;
    logic [1:0]        bsel;

    assign bsel = {byte_sel1_n, byte_sel0_n};

    dct_regs #(
        .W (DATA_W),
        .N (NREG)
    ) u_regs (
        .clk   (clk),
        .rst_n (srst_n),
        .wr_en (wr_en),
        .wdata (data_in),
        .rsel  (bsel),
        .rdata (rd_byte),
        .cfg   (cfg)
    );

    // Register access port
    dct_port_st_t p_st_reg;
    dct_port_st_t p_st_next;
    logic [1:0]   p_cnt_reg;
    logic [1:0]   p_cnt_next;
    logic         p_wr_reg;
    logic         p_wr_next;
    logic         p_oe_n_reg;
    logic         p_oe_n_next;
    logic         p_rdy_next;
    logic         xfer_ahead;
    logic         in_xfer_state;

    assign in_xfer_state = (p_st_reg == P_XFER);

    always_comb begin
        p_st_next  = p_st_reg;
        p_cnt_next = p_cnt_reg;
        p_wr_next  = p_wr_reg;
        case (p_st_reg)
            P_IDLE: begin
                if (!addr_strobe_n && port_sel) begin // R13
                    p_st_next  = P_WAIT;
                    p_wr_next  = wr_rd;
                    p_cnt_next = wr_rd ? PORT_WR_FIRST : PORT_RD_FIRST; // R12
                end
            end
            P_WAIT: begin
                p_cnt_next = p_cnt_reg - 2'h1;
                if (p_cnt_reg == 2'h1) begin
                    p_st_next = P_XFER;
                end
            end
            P_XFER: begin
                if (last_beat_n) begin // R13 R11
                    p_st_next  = P_WAIT;
                    p_cnt_next = p_wr_reg ? PORT_WR_NEXT : PORT_RD_NEXT; // R12
                end else begin
                    p_st_next = P_IDLE; // R19
                end
            end
            default: begin
                p_st_next = P_IDLE;
            end
        endcase
        xfer_ahead = (p_st_next == P_XFER); // R14
        p_rdy_next = xfer_ahead; // R14
        // Wait one cycle after the strobe so the transceiver has turned off
        p_oe_n_next = !(!p_wr_next && p_st_reg != P_IDLE && p_st_next != P_IDLE); // R17 R19
    end

    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            p_st_reg   <= P_IDLE;
            p_cnt_reg  <= 2'h0;
            p_wr_reg   <= 1'b0;
            p_oe_n_reg <= 1'b1;
        end else begin
            p_st_reg   <= p_st_next;
            p_cnt_reg  <= p_cnt_next;
            p_wr_reg   <= p_wr_next;
            p_oe_n_reg <= p_oe_n_next;
        end
    end

    // One load enable per byte, only in a write transfer
    always_comb begin
        wr_en = '0;
        if (in_xfer_state && p_wr_reg) begin
            wr_en[bsel] = 1'b1; // R15 R10
        end
    end

    // Configuration fields
    logic       fpm;
    logic       ads_dly;
    logic [1:0] rd_first;
    logic [1:0] rd_burst;
    logic [1:0] wr_first;

    always_comb begin
        fpm      = cfg[CFG_FPM_BIT]; // R7
        ads_dly  = cfg[CFG_ADS_DLY_BIT]; // R9 R8
        rd_first = cfg[CFG_RD_FIRST3_BIT] ? 2'h3 : 2'h2; // R2
        // FPM always needs the precharge wait between beats
        rd_burst = (cfg[CFG_RD_BURST1_BIT] || fpm) ? 2'h1 : 2'h0; // R3
        if (cfg[CFG_WR_FIRST3_BIT]) begin
            wr_first = 2'h3; // R4
        end else if (cfg[CFG_WR_FIRST2_BIT]) begin
            wr_first = 2'h2; // R4
        end else begin
            wr_first = 2'h1; // R5
        end
    end

    // Address strobe, optionally held back one clock
    logic ads_d_reg;
    logic ads_d_next;
    logic dsel_d_reg;
    logic dsel_d_next;
    logic dstart;

    always_comb begin
        ads_d_next  = !addr_strobe_n;
        dsel_d_next = dram_sel;
    end

    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            ads_d_reg  <= 1'b0;
            dsel_d_reg <= 1'b0;
        end else begin
            ads_d_reg  <= ads_d_next;
            dsel_d_reg <= dsel_d_next;
        end
    end

    // DRAM sequencer
    dct_dram_st_t d_st_reg;
    dct_dram_st_t d_st_next;
    logic [1:0]   d_cnt_reg;
    logic [1:0]   d_cnt_next;
    logic         d_wr_reg;
    logic         d_wr_next;
    logic         ras_n_reg;
    logic         ras_n_next;
    logic         cas_n_reg;
    logic         cas_n_next;
    logic         csel_reg;
    logic         csel_next;
    logic         cadv_reg;
    logic         cadv_next;
    logic         d_rdy_next;
    logic         edo_reg;
    logic         edo_next;
    logic [1:0]   first_w;

    assign dstart  = (!addr_strobe_n && dram_sel);
    assign first_w = wr_rd ? wr_first : rd_first;

    always_comb begin
        d_st_next  = d_st_reg;
        d_cnt_next = d_cnt_reg;
        d_wr_next  = d_wr_reg;
        cadv_next  = 1'b0;
        case (d_st_reg)
            D_IDLE: begin
                if (ads_dly ? (ads_d_reg && dsel_d_reg) : dstart) begin // R9
                    d_st_next  = D_ROW;
                    d_wr_next  = wr_rd;
                    // Strobe seen one clock late already costs the extra wait
                    d_cnt_next = first_w; // R6
                end else if (ads_dly && dstart) begin
                    d_st_next = D_DELAY; // R6
                    d_wr_next = wr_rd;
                end
            end
            D_DELAY: begin
                d_st_next  = D_ROW; // R6
                d_cnt_next = d_wr_reg ? wr_first : rd_first;
            end
            D_ROW: begin
                d_cnt_next = d_cnt_reg - 2'h1;
                if (d_cnt_reg == 2'h1) begin
                    d_st_next = D_COL; // R4
                    // EDO steps the column mid-way through the first strobe cycle too
                    cadv_next = !fpm; // R1
                end
            end
            D_COL: begin
                if (!last_beat_n) begin
                    d_st_next = D_IDLE;
                end else if (!d_wr_reg && rd_burst == 2'h0) begin
                    cadv_next = 1'b1; // R3 R1
                end else begin
                    d_st_next = D_PRE; // R2
                    cadv_next = fpm; // R1
                end
            end
            D_PRE: begin
                d_st_next = D_COL;
                cadv_next = !fpm; // R1
            end
            default: begin
                d_st_next = D_IDLE;
            end
        endcase
        // Delay state waits for the late strobe, so no row strobe yet
        ras_n_next = (d_st_next == D_IDLE || d_st_next == D_DELAY);
        cas_n_next = (d_st_next != D_COL);
        csel_next  = (d_st_next == D_COL || d_st_next == D_PRE);
        d_rdy_next = (d_st_next == D_COL);
        edo_next   = !fpm; // R7
    end

    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            d_st_reg  <= D_IDLE;
            d_cnt_reg <= 2'h0;
            d_wr_reg  <= 1'b0;
            ras_n_reg <= 1'b1;
            cas_n_reg <= 1'b1;
            csel_reg  <= 1'b0;
            cadv_reg  <= 1'b0;
            edo_reg   <= 1'b0;
        end else begin
            d_st_reg  <= d_st_next;
            d_cnt_reg <= d_cnt_next;
            d_wr_reg  <= d_wr_next;
            ras_n_reg <= ras_n_next;
            cas_n_reg <= cas_n_next;
            csel_reg  <= csel_next;
            cadv_reg  <= cadv_next;
            edo_reg   <= edo_next;
        end
    end

    // Ready merged ahead of the flop so the pin is a register output
    logic rdy_n_reg;
    logic rdy_n_next;

    always_comb begin
        rdy_n_next = !(p_rdy_next || d_rdy_next); // R14
    end

    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            rdy_n_reg <= 1'b1;
        end else begin
            rdy_n_reg <= rdy_n_next;
        end
    end

    // Both masters share the ready line; selects never overlap
    assign ready_n       = rdy_n_reg; // R14
    assign data_out      = rd_byte; // R16 R10
    assign data_oe_n     = p_oe_n_reg; // R17
    assign dram_ras_n    = ras_n_reg;
    assign dram_cas_n    = cas_n_reg;
    assign dram_col_sel  = csel_reg;
    assign dram_col_adv  = cadv_reg; // R1
    assign dram_edo_mode = edo_reg; // R1

endmodule : dct_top

// >>> tb/dct_dram_model.sv
// Behavioural DRAM bank: counts column strobe cycles in each row cycle.
// Assumes registered strobes from the sequencer; data pins are not modelled.
`timescale 1ns/1ps
module dct_dram_model (
    input  wire logic       clk,
    input  wire logic       dram_ras_n,
    input  wire logic       dram_cas_n,
    output logic      [7:0] beats
);
    logic ras_reg = 1'b1;
    always @(posedge clk) begin
        ras_reg <= dram_ras_n;
        if (!dram_ras_n && ras_reg)
            beats <= {7'h0, !dram_cas_n};
        else if (!dram_ras_n)
            beats <= beats + {7'h0, !dram_cas_n};
    end
endmodule : dct_dram_model

// >>> tb/dct_top_chk.sv
// Port-level assertions for dct_top: register port waits and DRAM strobe order.
// Assumes port_sel or dram_sel and wr_rd stay up for the whole access.
`timescale 1ns/1ps
module dct_top_chk
    import dct_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic              addr_strobe_n,
    input wire logic              port_sel,
    input wire logic              dram_sel,
    input wire logic              wr_rd,
    input wire logic              last_beat_n,
    input wire logic              byte_sel1_n,
    input wire logic              byte_sel0_n,
    input wire logic [DATA_W-1:0] data_in,
    input wire logic              data_oe_n,
    input wire logic              ready_n,
    input wire logic              dram_ras_n,
    input wire logic              dram_cas_n,
    input wire logic              dram_col_adv,
    input wire logic              dram_edo_mode
);
    logic dly_reg;
    logic dly_next;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Strobe delay bit snooped from port writes, so the row strobe figure is exact
    always_comb begin
        dly_next = dly_reg;
        if (!ready_n && dram_ras_n && data_oe_n && wr_rd && port_sel && {byte_sel1_n, byte_sel0_n} == IDX_CFG_HI)
            dly_next = data_in[CFG_ADS_DLY_BIT-8];
    end
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n) dly_reg <= CFG_RESET[CFG_ADS_DLY_BIT];
        else dly_reg <= dly_next;

    property p_rd_first; !addr_strobe_n && port_sel && !wr_rd |-> ready_n [*4] ##1 !ready_n; endproperty
    a_rd_first: assert property (p_rd_first) else $error("port read first beat late or early");
    property p_wr_first; !addr_strobe_n && port_sel && wr_rd |-> ready_n [*3] ##1 (!ready_n && data_oe_n); endproperty
    a_wr_first: assert property (p_wr_first) else $error("port write first beat wrong");
    property p_oe_start; $fell(data_oe_n) |-> $past(addr_strobe_n, 2) == 1'b0 && port_sel && !wr_rd; endproperty
    a_oe_start: assert property (p_oe_start) else $error("output enable not two cycles after read strobe");
    property p_rd_next; !ready_n && !data_oe_n && last_beat_n |=> ready_n [*2] ##1 !ready_n; endproperty
    a_rd_next: assert property (p_rd_next) else $error("port read burst beat spacing wrong");
    property p_wr_next; !ready_n && dram_ras_n && data_oe_n && last_beat_n |=> ready_n ##1 !ready_n; endproperty
    a_wr_next: assert property (p_wr_next) else $error("port write burst beat spacing wrong");
    property p_port_end; !ready_n && dram_ras_n && !last_beat_n |=> ready_n && data_oe_n; endproperty
    a_port_end: assert property (p_port_end) else $error("port access did not end after last beat");
    property p_ras; !addr_strobe_n && dram_sel |=> (dram_ras_n == dly_reg) ##1 !dram_ras_n; endproperty
    a_ras: assert property (p_ras) else $error("row strobe delay wrong");
    property p_col_adv; dram_col_adv |-> dram_cas_n == !dram_edo_mode; endproperty
    a_col_adv: assert property (p_col_adv) else $error("column step in wrong strobe phase");
    property p_dram_oe; !dram_ras_n |-> data_oe_n; endproperty
    a_dram_oe: assert property (p_dram_oe) else $error("data driven during DRAM access");
    property p_fpm_beat; !dram_cas_n && !dram_ras_n && !dram_edo_mode && last_beat_n |=> dram_cas_n ##1 !dram_cas_n; endproperty
    a_fpm_beat: assert property (p_fpm_beat) else $error("FPM burst beat not one wait");
    property p_edo_adv; !dram_cas_n && dram_edo_mode |-> dram_col_adv; endproperty
    a_edo_adv: assert property (p_edo_adv) else $error("EDO strobe cycle without column step");
    property p_fpm_adv; !dram_cas_n && !dram_ras_n && !dram_edo_mode && last_beat_n |=> dram_col_adv; endproperty
    a_fpm_adv: assert property (p_fpm_adv) else $error("FPM column step missing in precharge");

    c_rd_burst: cover property (!ready_n && !data_oe_n && last_beat_n);
    c_edo_zero: cover property (!dram_cas_n && dram_edo_mode ##1 !dram_cas_n);
    c_dly: cover property (!addr_strobe_n && dram_sel && dly_reg);
endmodule : dct_top_chk

bind dct_top dct_top_chk i_chk (.clk, .rst_n, .addr_strobe_n, .port_sel, .dram_sel, .wr_rd, .last_beat_n,
    .byte_sel1_n, .byte_sel0_n, .data_in, .data_oe_n, .ready_n, .dram_ras_n, .dram_cas_n, .dram_col_adv,
    .dram_edo_mode);

// >>> tb/tb.sv
// Self-checking bench for dct_top: register port bursts and DRAM wait profiles.
// Assumes a 200 MHz clock; inputs change 1 ns after the rising edge.
`timescale 1ns/1ps
module tb
    import dct_pkg::*;
;
    logic              clk = 0, rst_n = 0, addr_strobe_n = 1, port_sel = 0, dram_sel = 0, wr_rd = 0;
    logic              last_beat_n = 1, byte_sel1_n = 1, byte_sel0_n = 1, data_oe_n, ready_n;
    logic              slowbus_dir = 1;
    logic              dram_ras_n, dram_cas_n, dram_col_sel, dram_col_adv, dram_edo_mode;
    logic [DATA_W-1:0] data_in = 8'h00, data_out;
    logic [7:0]        mem [4];
    logic [7:0]        beats;
    int                n_errors, comparisons, cyc;

    always #2.5 clk = ~clk;

    dct_top i_dut (.clk, .rst_n, .addr_strobe_n, .port_sel, .dram_sel, .wr_rd, .last_beat_n, .byte_sel1_n,
        .byte_sel0_n, .data_in, .data_out, .data_oe_n, .ready_n, .dram_ras_n, .dram_cas_n, .dram_col_sel,
        .dram_col_adv, .dram_edo_mode);
    dct_dram_model i_mem (.clk, .dram_ras_n, .dram_cas_n, .beats);

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk

    task automatic print_verdict();
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : print_verdict

    // Transceiver faces the slow bus unless a port read is under way
    always @(negedge clk) begin
        if (slowbus_dir === 1'b1 && rst_n) chk("contention", data_oe_n, 1);
    end

    // One access; e0 and en are the cycles to the first and each later beat, er the row strobe cycle
    task automatic acc(input logic dr, input logic w, input int nb, input logic [1:0] s0,
                       input logic [31:0] d, input int e0, input int en, input int er);
        int n;
        int r;
        logic [1:0] ix;
        @(posedge clk);
        #1;
        addr_strobe_n = 0;
        port_sel = !dr;
        slowbus_dir = dr | w;
        dram_sel = dr;
        wr_rd = w;
        for (int b = 0; b < nb; b++) begin
            n = 0;
            r = 0;
            if (b > 0) begin
                @(posedge clk);
                #1;
                n = 1;
            end
            ix = s0 + 2'(b);
            {byte_sel1_n, byte_sel0_n} = ix;
            data_in = d[8*b +: 8];
            last_beat_n = (b != nb - 1);
            while (ready_n !== 1'b0 && n < 20) begin
                @(posedge clk);
                #1;
                addr_strobe_n = 1;
                n++;
                if (r == 0 && dram_ras_n === 1'b0) r = n;
            end
            if (dr && b == 0) chk("ras_cycle", r, er);
            chk("wait", n, b ? en : e0);
            chk("oe_n", data_oe_n, dr | w);
            chk("col_sel", dram_col_sel, dr);
            chk("cas_n", dram_cas_n, !dr);
            if (!dr && !w) chk("rdata", data_out, mem[ix]);
            if (!dr && w) mem[ix] = d[8*b +: 8];
        end
        @(posedge clk);
        #1;
        chk("idle", {ready_n, data_oe_n, dram_ras_n}, 3'b111);
        if (dr) chk("beats", beats, nb);
        port_sel = 0;
        dram_sel = 0;
        slowbus_dir = 1;
        last_beat_n = 1;
    endtask : acc

    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_errors++;
            print_verdict();
        end
    end

    initial begin
        mem = '{CFG_RESET[7:0], CFG_RESET[15:8], REG_RESET, REG_RESET};
        repeat (3) @(posedge clk);
        #1;
        rst_n = 1;
        repeat (3) @(posedge clk);
        acc(0, 0, 4, 0, 0, 4, 3, 0);
        acc(1, 0, 1, 0, 0, 4, 0, 1);
        acc(1, 1, 1, 0, 0, 4, 0, 1);
        acc(0, 1, 4, 0, 32'h5aa5_8026, 3, 2, 0);
        acc(0, 0, 2, 2, 0, 4, 3, 0);
        acc(1, 0, 4, 0, 0, 3, 2, 1);
        chk("edo", dram_edo_mode, 0);
        acc(1, 1, 3, 0, 0, 3, 2, 1);
        acc(0, 1, 2, 0, 32'h0000_0402, 3, 2, 0);
        acc(1, 0, 4, 0, 0, 4, 1, 2);
        chk("edo", dram_edo_mode, 1);
        acc(1, 1, 1, 0, 0, 3, 0, 2);
        acc(0, 0, 2, 0, 0, 4, 3, 0);
        print_verdict();
    end
endmodule : tb
